// file: hdl/rsie_core.sv
// execution of rotate-through-carry and sleep, with AXI4-Lite registers
// assumes one clock; software supplies each instruction word by register write
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Opcode 00 1101 dfff ffff rotates the file byte left: bit 7 to carry, carry to bit 0.
// - Opcode 00 1100 dfff ffff rotates the file byte right: bit 0 to carry, carry to bit 7.
// - A rotate result goes to the accumulator when d is 0 and back to the file byte when 1.
// - A rotate takes four clock cycles, one per phase: decode, read, process, write.
// - The fixed word 00 0000 0110 0011 is the operand-less sleep instruction.
// - Sleep clears the low-active power-down flag and sets the low-active time-out flag.
// - Sleep loads the watchdog counter with 00h and clears its prescaler.
// - After sleep the oscillator halts and nothing executes until a wake-up.
module rsie_core
  import rsie_pkg::*;
#(
  parameter int WDOG_W = 8,
  parameter int PRESC_W = 8
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [7:0] awaddr_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [7:0] araddr_i,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic osc_halt_o,
  output logic expiry_flag_n_o,
  output logic sleep_entry_flag_n_o
);

  typedef struct packed {
    rsie_phase_t phase;
    rsie_op_t op;
    logic [13:0] instr;
    logic dest;
    logic [6:0] faddr;
    logic [7:0] operand;
    logic [7:0] result;
    logic carry_new;
    logic [7:0] acc;
    logic c;
    logic dc;
    logic z;
    logic expiry_flag_n;
    logic sleep_entry_flag_n;
    logic asleep;
    logic [WDOG_W-1:0] watchdog_counter;
    logic [PRESC_W-1:0] presc;
    logic [6:0] sw_addr;
    logic [127:0][7:0] file;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rsie_state_t;

  rsie_state_t st;
  rsie_state_t next_st;
  logic [7:0] rot_result;
  logic rot_carry;

  rsie_rotate rsie_rotate_inst (
    .data_i(st.operand),
    .carry_i(st.c),
    .left_i(st.op == OP_RL),
    .result_o(rot_result),
    .carry_o(rot_carry)
  );

  always_comb
  begin
    logic idle;
    logic [31:0] wv;
    logic [7:0] st_byte;
    idle = (st.phase == PH_IDLE);
    wv = '0;
    st_byte = '0;
    next_st = st;

    // watchdog keeps its own time, sleep or not
    next_st.presc = st.presc + 1'b1;
    if (&st.presc)
      next_st.watchdog_counter = st.watchdog_counter + 1'b1;

    case (st.phase)
      PH_IDLE: next_st.phase = PH_IDLE;
      PH_Q1:
      begin
        next_st.op = decode_op(st.instr);
        next_st.dest = st.instr[DEST_BIT];
        next_st.faddr = st.instr[FADDR_HI:0];
        next_st.phase = PH_Q2;
      end
      PH_Q2:
      begin
        next_st.operand = st.file[st.faddr];
        next_st.phase = PH_Q3;
      end
      PH_Q3:
      begin
        next_st.result = rot_result;
        next_st.carry_new = rot_carry;
        next_st.phase = PH_Q4;
      end
      PH_Q4:
      begin
        next_st.phase = PH_IDLE;
        case (st.op)
          OP_RL, OP_RR:
          begin
            if (st.dest)
              next_st.file[st.faddr] = st.result;
            else
              next_st.acc = st.result;
            next_st.c = st.carry_new;
          end
          OP_SLEEP:
          begin
            next_st.watchdog_counter = '0;
            next_st.presc = '0;
            next_st.expiry_flag_n = 1'b1;
            next_st.sleep_entry_flag_n = 1'b0;
            next_st.asleep = 1'b1;
          end
          default: next_st.op = OP_NONE;
        endcase
      end
      default: next_st.phase = PH_IDLE;
    endcase

    // write channel: address and data may arrive in either order
    if (awvalid_i && st.awready)
    begin
      next_st.aw_have = 1'b1;
      next_st.aw_addr = awaddr_i;
    end
    if (wvalid_i && st.wready)
    begin
      next_st.w_have = 1'b1;
      next_st.wdata = wdata_i;
      next_st.wstrb = wstrb_i;
    end
    if (st.bvalid && bready_i)
      next_st.bvalid = 1'b0;
    if (st.aw_have && st.w_have && !st.bvalid)
    begin
      next_st.aw_have = 1'b0;
      next_st.w_have = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      // execution owns acc, status and file while busy, so those writes drop
      case (st.aw_addr)
        REG_INSTR:
        begin
          wv = apply_strb({18'h00000, st.instr}, st.wdata, st.wstrb);
          if (idle && !st.asleep)
          begin
            next_st.instr = wv[INSTR_W-1:0];
            next_st.phase = PH_Q1;
          end
        end
        REG_ACC:
        begin
          wv = apply_strb({24'h000000, st.acc}, st.wdata, st.wstrb);
          if (idle)
            next_st.acc = wv[7:0];
        end
        REG_STATUS:
        begin
          wv = apply_strb(32'h00000000, st.wdata, st.wstrb);
          if (idle && st.wstrb[0])
          begin
            next_st.c = wv[ST_C];
            next_st.dc = wv[ST_DC];
            next_st.z = wv[ST_Z];
          end
        end
        REG_FILE_ADDR:
        begin
          wv = apply_strb({25'h0000000, st.sw_addr}, st.wdata, st.wstrb);
          next_st.sw_addr = wv[FADDR_HI:0];
        end
        REG_FILE_DATA:
        begin
          wv = apply_strb({24'h000000, st.file[st.sw_addr]}, st.wdata, st.wstrb);
          if (idle)
            next_st.file[st.sw_addr] = wv[7:0];
        end
        REG_WDOG: next_st.bresp = RESP_OKAY;
        // a sleep landing in this same cycle wins over the wake
        REG_WAKE:
        begin
          if (st.asleep)
            next_st.asleep = 1'b0;
        end
        default: next_st.bresp = RESP_SLVERR;
      endcase
    end
    next_st.awready = !next_st.aw_have && !next_st.bvalid;
    next_st.wready = !next_st.w_have && !next_st.bvalid;

    // read channel: data registered on the same edge that takes the address
    if (st.rvalid && rready_i)
      next_st.rvalid = 1'b0;
    if (arvalid_i && st.arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      st_byte = '0;
      st_byte[ST_C] = st.c;
      st_byte[ST_DC] = st.dc;
      st_byte[ST_Z] = st.z;
      st_byte[ST_PD_N] = st.sleep_entry_flag_n;
      st_byte[ST_TO_N] = st.expiry_flag_n;
      st_byte[ST_ASLEEP] = st.asleep;
      st_byte[ST_BUSY] = !idle;
      case (araddr_i)
        REG_INSTR: next_st.rdata = {18'h00000, st.instr};
        REG_ACC: next_st.rdata = {24'h000000, st.acc};
        REG_STATUS: next_st.rdata = {24'h000000, st_byte};
        REG_FILE_ADDR: next_st.rdata = {25'h0000000, st.sw_addr};
        REG_FILE_DATA: next_st.rdata = {24'h000000, st.file[st.sw_addr]};
        REG_WDOG: next_st.rdata = 32'({st.presc, st.watchdog_counter});
        REG_WAKE: next_st.rdata = 32'h00000000;
        default:
        begin
          next_st.rdata = 32'h00000000;
          next_st.rresp = RESP_SLVERR;
        end
      endcase
    end
    next_st.arready = !next_st.rvalid;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st <= '0;
      st.expiry_flag_n <= 1'b1;
      st.sleep_entry_flag_n <= 1'b1;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign awready_o = st.awready;
  assign wready_o = st.wready;
  assign bvalid_o = st.bvalid;
  assign bresp_o = st.bresp;
  assign arready_o = st.arready;
  assign rvalid_o = st.rvalid;
  assign rdata_o = st.rdata;
  assign rresp_o = st.rresp;
  assign osc_halt_o = st.asleep;
  assign expiry_flag_n_o = st.expiry_flag_n;
  assign sleep_entry_flag_n_o = st.sleep_entry_flag_n;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic is_rot;
  assign is_rot = (st.op == OP_RL) || (st.op == OP_RR);

  a_rotate_left_math: assert property (
    (st.phase == PH_Q3 && st.op == OP_RL) |=>
      (st.result == {$past(st.operand[6:0]), $past(st.c)}) &&
      (st.carry_new == $past(st.operand[7])))
    else $error("rotate left result or carry wrong");
  a_rotate_right_math: assert property (
    (st.phase == PH_Q3 && st.op == OP_RR) |=>
      (st.result == {$past(st.c), $past(st.operand[7:1])}) &&
      (st.carry_new == $past(st.operand[0])))
    else $error("rotate right result or carry wrong");
  a_dest_acc_write: assert property (
    (st.phase == PH_Q4 && is_rot && !st.dest) |=>
      (st.acc == $past(st.result)) && (st.c == $past(st.carry_new)))
    else $error("rotate result missing from accumulator");
  a_dest_file_write: assert property (
    (st.phase == PH_Q4 && is_rot && st.dest) |=>
      (st.file[$past(st.faddr)] == $past(st.result)) && $stable(st.acc))
    else $error("rotate result missing from file byte");
  a_phase_walk: assert property (
    (st.phase == PH_Q1) |=> (st.phase == PH_Q2) ##1 (st.phase == PH_Q3)
      ##1 (st.phase == PH_Q4) ##1 (st.phase == PH_IDLE))
    else $error("instruction did not walk four phases");
  a_sleep_decode: assert property (
    (st.phase == PH_Q1 && st.instr == SLEEP_OPCODE) |=> (st.op == OP_SLEEP))
    else $error("sleep word not decoded");
  a_sleep_flags: assert property (
    (st.phase == PH_Q4 && st.op == OP_SLEEP) |=>
      (!sleep_entry_flag_n_o && expiry_flag_n_o))
    else $error("sleep status flags wrong");
  a_sleep_wdog_clear: assert property (
    (st.phase == PH_Q4 && st.op == OP_SLEEP) |=>
      (st.watchdog_counter == WDOG_CLEAR[WDOG_W-1:0]) && (st.presc == '0))
    else $error("watchdog not cleared by sleep");
  a_sleep_halts: assert property (
    (st.asleep) |=> (st.phase == PH_IDLE) && (osc_halt_o || $past(st.aw_addr) == REG_WAKE))
    else $error("execution while asleep");
  a_rot_flags_kept: assert property (
    (st.phase == PH_Q4 && is_rot) |=> $stable(st.dc) && $stable(st.z) &&
      $stable(st.expiry_flag_n) && $stable(st.sleep_entry_flag_n))
    else $error("rotate touched a flag other than carry");

  c_rotate_left_file: cover property (st.phase == PH_Q4 && st.op == OP_RL && st.dest);
  c_rotate_right_acc: cover property (st.phase == PH_Q4 && st.op == OP_RR && !st.dest);
  c_sleep_entry: cover property (st.phase == PH_Q4 && st.op == OP_SLEEP);
  c_wake_up: cover property (st.asleep ##1 !st.asleep);

endmodule
`default_nettype wire

// file: hdl/rsie_pkg.sv
// constants, types and helpers for the rotate/sleep execution block
// assumes a 32-bit AXI4-Lite register port and a 14-bit instruction word
package rsie_pkg;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_Q1 = 3'b001,
    PH_Q2 = 3'b010,
    PH_Q3 = 3'b011,
    PH_Q4 = 3'b100
  } rsie_phase_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_RL = 2'b01,
    OP_RR = 2'b10,
    OP_SLEEP = 2'b11
  } rsie_op_t;

  // register byte offsets
  localparam logic [7:0] REG_INSTR = 8'h00;
  localparam logic [7:0] REG_ACC = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_FILE_ADDR = 8'h0C;
  localparam logic [7:0] REG_FILE_DATA = 8'h10;
  localparam logic [7:0] REG_WDOG = 8'h14;
  localparam logic [7:0] REG_WAKE = 8'h18;

  // instruction fields
  localparam int INSTR_W = 14;
  localparam int OPC_HI = 13;
  localparam int OPC_LO = 8;
  localparam int DEST_BIT = 7;
  localparam int FADDR_HI = 6;
  localparam logic [5:0] OPC_ROT_LEFT = 6'h0D;
  localparam logic [5:0] OPC_ROT_RIGHT = 6'h0C;
  localparam logic [13:0] SLEEP_OPCODE = 14'h0063;

  // status bit positions
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_PD_N = 3;
  localparam int ST_TO_N = 4;
  localparam int ST_ASLEEP = 5;
  localparam int ST_BUSY = 6;

  localparam logic [7:0] WDOG_CLEAR = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic rsie_op_t decode_op(input logic [13:0] instr);
    if (instr == SLEEP_OPCODE)
    begin
      return OP_SLEEP;
    end
    else if (instr[OPC_HI:OPC_LO] == OPC_ROT_LEFT)
    begin
      return OP_RL;
    end
    else if (instr[OPC_HI:OPC_LO] == OPC_ROT_RIGHT)
    begin
      return OP_RR;
    end
    return OP_NONE;
  endfunction

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] v;
    v = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        v[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return v;
  endfunction

endpackage

// file: hdl/rsie_rotate.sv
// one-bit rotate of a byte through a carry bit
// purely combinational; the caller registers the outputs
`timescale 1ns/10ps
`default_nettype none
module rsie_rotate
  import rsie_pkg::*;
(
  input wire logic [7:0] data_i,
  input wire logic carry_i,
  input wire logic left_i,
  output logic [7:0] result_o,
  output logic carry_o
);

  always_comb
  begin
    if (left_i)
    begin
      result_o = {data_i[6:0], carry_i};
      carry_o = data_i[7];
    end
    else
    begin
      result_o = {carry_i, data_i[7:1]};
      carry_o = data_i[0];
    end
  end

endmodule
`default_nettype wire

// file: dv/rsie_core_test.sv
// self-checking bench for the rotate/sleep execution block
// assumes rsie_core alone, driven by an AXI4-Lite master in this module
`timescale 1ns/10ps
`default_nettype none
module rsie_core_test
  import rsie_pkg::*;
;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, halt, exp_n, slp_n;
  logic [1:0] bresp, rresp, last_bresp;
  // each note: response, mask, masked expected data
  logic [65:0] notes[$];
  logic [65:0] nt;
  int num_errors = 0;
  int checks_done = 0;
  logic [6:0] fa;
  logic [7:0] acc, fb, res;
  logic [5:0] op;
  logic c, nc, d;
  logic [1:0] zdc;
  int kind;

  rsie_core rsie_core_inst (.clk_i(clk_i), .rst_i(rst_i), .awvalid_i(awvalid),
    .awready_o(awready), .awaddr_i(awaddr), .wvalid_i(wvalid), .wready_o(wready),
    .wdata_i(wdata), .wstrb_i(wstrb), .bvalid_o(bvalid), .bready_i(bready),
    .bresp_o(bresp), .arvalid_i(arvalid), .arready_o(arready), .araddr_i(araddr),
    .rvalid_o(rvalid), .rready_i(rready), .rdata_o(rdata), .rresp_o(rresp),
    .osc_halt_o(halt), .expiry_flag_n_o(exp_n), .sleep_entry_flag_n_o(slp_n));

  always #2 clk_i = ~clk_i;

  task automatic end_of_test();
    if (notes.size() != 0)
      num_errors++;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [33:0] got, input logic [33:0] want);
    checks_done++;
    if (got !== want)
    begin
      num_errors++;
      $display("BAD at %0t got %h want %h", $time, got, want);
    end
  endtask

  // a stuck handshake ends the run instead of hanging it
  task automatic tick(inout int n);
    n++;
    if (n > 100)
    begin
      num_errors++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n = 0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge clk_i);
      if (awready === 1'h1)
        awvalid <= 1'h0;
      if (wready === 1'h1)
        wvalid <= 1'h0;
      tick(n);
    end
    while (bvalid !== 1'h1);
    last_bresp = bresp;
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v,
                    input logic [1:0] r = RESP_OKAY);
    int n = 0;
    @(posedge clk_i);
    notes.push_back({r, m, v});
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge clk_i);
      if (arready === 1'h1)
        arvalid <= 1'h0;
      tick(n);
    end
    while (rvalid !== 1'h1);
    rready <= 1'h0;
  endtask

  // the oldest note is judged at every read handshake
  always @(posedge clk_i)
  begin
    if (rvalid === 1'h1 && rready === 1'h1)
    begin
      if (notes.size() == 0)
        check(34'h0, 34'h3FFFFFFFF);
      else
      begin
        nt = notes.pop_front();
        check({rresp, rdata & nt[63:32]}, {nt[65:64], nt[31:0]});
      end
    end
  end

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    void'($urandom(2));
    rd(REG_STATUS, 32'h7F, 32'h18);
    for (int i = 0; i < 30; i++)
    begin
      fa = 7'($urandom);
      fb = 8'($urandom);
      acc = 8'($urandom);
      c = 1'($urandom);
      d = 1'($urandom);
      zdc = 2'($urandom);
      kind = $urandom_range(2, 0);
      op = (kind == 0) ? OPC_ROT_LEFT : (kind == 1) ? OPC_ROT_RIGHT : 6'h0B;
      res = (kind == 0) ? {fb[6:0], c} : {c, fb[7:1]};
      nc = (kind == 0) ? fb[7] : fb[0];
      wr(REG_FILE_ADDR, {25'h0, fa});
      wr(REG_FILE_DATA, {24'h0, fb});
      wr(REG_ACC, {24'h0, acc});
      wr(REG_STATUS, {29'h0, zdc, c});
      wr(REG_INSTR, {18'h0, op, d, fa});
      repeat (4) @(posedge clk_i);
      if (kind < 2 && !d)
        acc = res;
      if (kind < 2 && d)
        fb = res;
      if (kind < 2)
        c = nc;
      rd(REG_ACC, 32'hFF, {24'h0, acc});
      rd(REG_FILE_DATA, 32'hFF, {24'h0, fb});
      rd(REG_STATUS, 32'h07, {29'h0, zdc, c});
    end
    // let the watchdog run so that the clear is visible
    repeat (600) @(posedge clk_i);
    wr(REG_INSTR, {18'h0, SLEEP_OPCODE});
    repeat (4) @(posedge clk_i);
    check({31'h0, halt, exp_n, slp_n}, {31'h0, 3'h6});
    rd(REG_WDOG, 32'hFFFFF0FF, 32'h0);
    rd(REG_STATUS, 32'h78, 32'h30);
    wr(REG_INSTR, {18'h0, OPC_ROT_LEFT, 1'h0, fa});
    repeat (4) @(posedge clk_i);
    rd(REG_ACC, 32'hFF, {24'h0, acc});
    check({33'h0, halt}, 34'h1);
    wr(REG_WAKE, 32'h0);
    check({31'h0, halt, exp_n, slp_n}, {31'h0, 3'h2});
    check({32'h0, last_bresp}, {32'h0, RESP_OKAY});
    wr(8'h1C, 32'hFFFFFFFF);
    check({32'h0, last_bresp}, {32'h0, RESP_SLVERR});
    rd(8'h1C, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
    repeat (4) @(posedge clk_i);
    end_of_test();
  end
endmodule
`default_nettype wire
